// ===== verilog/can_accept_pkg.sv
// constants for the acceptance filter register block
// Functional notes
// - six buffer direction bits, one means transmit
// - direction register modes 1-3 only, resets zero
// - sixteen filters; 6-15 only in modes 1-3
// - filter high byte: sid 10:3 or eid 28:21
// - filter low 7:5: sid 2:0 or eid 20:18
// - low bit 3 selects extended or standard frames
// - low 1:0 eid 17:16; two eid bytes; bits 4,2 zero
// - two masks; high byte masks upper id bits
// - mask low 7:5 masks id bits; bits 4,2 zero
// - mask bit 3 set obeys filter frame select
// - mask bit 3 absent in mode 0, resets zero
// - mask low 1:0 and ext high byte hold mask bits
// - per-filter enable; disabled filters never match
package can_accept_pkg;
   localparam int          NUM_FILTERS  = 16;
   localparam int          NUM_MASKS    = 2;
   localparam int          NUM_BUFFERS  = 6;
   localparam int          BASE_FILTERS = 6;
   localparam logic [11:0] ADDR_BSEL    = 12'h000;
   localparam logic [11:0] ADDR_MODE    = 12'h004;
   localparam logic [11:0] ADDR_FEN     = 12'h008;
   localparam logic [11:0] ADDR_ID      = 12'h00c;
   localparam logic [11:0] ADDR_RESULT  = 12'h010;
   localparam logic [11:0] ADDR_FILT    = 12'h100;
   localparam logic [11:0] ADDR_MASK    = 12'h200;
   localparam logic [1:0]  MODE_LEGACY  = 2'h0;
   localparam logic [7:0]  BSEL_IMPL    = 8'hfc;
   localparam logic [7:0]  SIDL_IMPL    = 8'he3;
   localparam int          EXT_BIT      = 3;
   localparam logic [15:0] FEN_RESET    = 16'h003f;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage // can_accept_pkg

// ===== verilog/can_accept_filter.sv
// acceptance filter registers and match logic behind an axi4-lite slave
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module can_accept_filter (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // received identifier from the protocol engine
   input  wire logic [28:0] rx_id,
   input  wire logic        rx_ext,
   input  wire logic        rx_valid,
   // acceptance result
   output logic             rx_accept,
   output logic [3:0]       rx_filter_hit,
   output logic             rx_done,
   // buffer directions to the buffer logic
   output logic [5:0]       buffer_tx_direction_bits
);
   // per filter: {id_high, id_low, ext_id_high, ext_id_low}
   logic [7:0]  filter_id_high     [can_accept_pkg::NUM_FILTERS];
   logic [7:0]  filter_id_low      [can_accept_pkg::NUM_FILTERS];
   logic [7:0]  filter_ext_id_high [can_accept_pkg::NUM_FILTERS];
   logic [7:0]  filter_ext_id_low  [can_accept_pkg::NUM_FILTERS];
   logic [7:0]  mask_id_high       [can_accept_pkg::NUM_MASKS];
   logic [7:0]  mask_id_low        [can_accept_pkg::NUM_MASKS];
   logic [7:0]  mask_ext_id_high   [can_accept_pkg::NUM_MASKS];
   logic [7:0]  mask_ext_id_low    [can_accept_pkg::NUM_MASKS];
   logic        mask_ext_sel       [can_accept_pkg::NUM_MASKS];
   logic [7:0]  buffer_direction_select;
   logic [1:0]  op_mode;
   logic [15:0] filter_enable_bit;
   logic [15:0] filter_mask_sel;
   logic        last_accept;
   logic [3:0]  last_hit;

   // write channel: address and data latched independently
   logic        aw_held, w_held;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        next_aw_held, next_w_held;
   logic [11:0] next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0]  next_w_strb;
   logic        do_write, next_bvalid;
   logic [1:0]  next_bresp;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;

   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
      end
   end

   always_comb begin
      next_bvalid = s_axi_bvalid;
      next_bresp  = s_axi_bresp;
      if (s_axi_bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      if (do_write) begin
         next_bvalid = 1'b1;
         next_bresp  = addr_ok(aw_addr) ? can_accept_pkg::RESP_OKAY
                                        : can_accept_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 12'h000;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else begin
         aw_held      <= next_aw_held;
         w_held       <= next_w_held;
         aw_addr      <= next_aw_addr;
         w_data       <= next_w_data;
         w_strb       <= next_w_strb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp  <= next_bresp;
      end
   end

   // address check; filters above five need mode 1, 2 or 3
   function automatic logic addr_ok(input logic [11:0] a);
      logic legacy;
      legacy = (op_mode == can_accept_pkg::MODE_LEGACY);
      if (a[1:0] != 2'h0)
         addr_ok = 1'b0;
      else if (a == can_accept_pkg::ADDR_BSEL)
         addr_ok = !legacy;
      else if (a == can_accept_pkg::ADDR_MODE || a == can_accept_pkg::ADDR_ID
               || a == can_accept_pkg::ADDR_RESULT)
         addr_ok = 1'b1;
      else if (a == can_accept_pkg::ADDR_FEN)
         addr_ok = !legacy;
      else if (a[11:6] == can_accept_pkg::ADDR_FILT[11:6])
         addr_ok = !legacy || (a[5:2] < 4'(can_accept_pkg::BASE_FILTERS));
      else if (a[11:3] == can_accept_pkg::ADDR_MASK[11:3])
         addr_ok = 1'b1;
      else
         addr_ok = 1'b0;
   endfunction

   // register writes; identifier bytes carry no reset value
   logic       wr_filt, wr_mask;
   logic [3:0] wr_fidx;
   logic       wr_midx;
   assign wr_filt = do_write && addr_ok(aw_addr)
                    && aw_addr[11:6] == can_accept_pkg::ADDR_FILT[11:6];
   assign wr_mask = do_write && addr_ok(aw_addr)
                    && aw_addr[11:3] == can_accept_pkg::ADDR_MASK[11:3];
   assign wr_fidx = aw_addr[5:2];
   assign wr_midx = aw_addr[2];

   always_ff @(posedge aclk) begin
      if (wr_filt) begin
         if (w_strb[3]) filter_id_high[wr_fidx] <= w_data[31:24];
         if (w_strb[2]) filter_id_low[wr_fidx] <=
            w_data[23:16] & can_accept_pkg::SIDL_IMPL |
            (w_data[23:16] & 8'h08);
         if (w_strb[1]) filter_ext_id_high[wr_fidx] <= w_data[15:8];
         if (w_strb[0]) filter_ext_id_low[wr_fidx]  <= w_data[7:0];
      end
      if (wr_mask) begin
         if (w_strb[3]) mask_id_high[wr_midx] <= w_data[31:24];
         if (w_strb[2]) mask_id_low[wr_midx] <=
            w_data[23:16] & can_accept_pkg::SIDL_IMPL;
         if (w_strb[1]) mask_ext_id_high[wr_midx] <= w_data[15:8];
         if (w_strb[0]) mask_ext_id_low[wr_midx]  <= w_data[7:0];
      end
   end

   // control registers with defined reset values
   logic [7:0]  next_bsel;
   logic [1:0]  next_mode;
   logic [15:0] next_fen, next_msel;
   logic        next_mext0, next_mext1;
   always_comb begin
      next_bsel  = buffer_direction_select;
      next_mode  = op_mode;
      next_fen   = filter_enable_bit;
      next_msel  = filter_mask_sel;
      next_mext0 = mask_ext_sel[0];
      next_mext1 = mask_ext_sel[1];
      if (do_write && addr_ok(aw_addr)) begin
         if (aw_addr == can_accept_pkg::ADDR_BSEL && w_strb[0])
            next_bsel = w_data[7:0] & can_accept_pkg::BSEL_IMPL;
         if (aw_addr == can_accept_pkg::ADDR_MODE && w_strb[0])
            next_mode = w_data[1:0];
         if (aw_addr == can_accept_pkg::ADDR_FEN) begin
            if (w_strb[0]) next_fen[7:0]  = w_data[7:0];
            if (w_strb[1]) next_fen[15:8] = w_data[15:8];
            if (w_strb[2]) next_msel[7:0]  = w_data[23:16];
            if (w_strb[3]) next_msel[15:8] = w_data[31:24];
         end
         if (wr_mask && w_strb[2] && op_mode != can_accept_pkg::MODE_LEGACY)
         begin
            if (wr_midx) next_mext1 = w_data[16 + can_accept_pkg::EXT_BIT];
            else         next_mext0 = w_data[16 + can_accept_pkg::EXT_BIT];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         buffer_direction_select <= 8'h00;
         op_mode                 <= can_accept_pkg::MODE_LEGACY;
         filter_enable_bit       <= can_accept_pkg::FEN_RESET;
         filter_mask_sel         <= 16'h0000;
         mask_ext_sel[0]         <= 1'b0;
         mask_ext_sel[1]         <= 1'b0;
      end else begin
         buffer_direction_select <= next_bsel;
         op_mode                 <= next_mode;
         filter_enable_bit       <= next_fen;
         filter_mask_sel         <= next_msel;
         mask_ext_sel[0]         <= next_mext0;
         mask_ext_sel[1]         <= next_mext1;
      end
   end
   assign buffer_tx_direction_bits = buffer_direction_select[7:2];

   // acceptance: lowest enabled matching filter wins
   function automatic logic filt_match(input int f);
      logic [28:0] fid, mid;
      logic        m, fext, mext;
      m    = filter_mask_sel[f];
      fext = filter_id_low[f][can_accept_pkg::EXT_BIT];
      mext = (op_mode == can_accept_pkg::MODE_LEGACY) ? 1'b1 : mask_ext_sel[m];
      if (fext) begin
         fid = {filter_id_high[f], filter_id_low[f][7:5], filter_id_low[f][1:0],
                filter_ext_id_high[f], filter_ext_id_low[f]};
         mid = {mask_id_high[m], mask_id_low[m][7:5], mask_id_low[m][1:0],
                mask_ext_id_high[m], mask_ext_id_low[m]};
      end else if (rx_ext) begin
         // a standard filter sees the base id, top 11 bits of an extended id
         fid = {filter_id_high[f], filter_id_low[f][7:5], 18'h00000};
         mid = {mask_id_high[m], mask_id_low[m][7:5], 18'h00000};
      end else begin
         fid = {18'h00000, filter_id_high[f], filter_id_low[f][7:5]};
         mid = {18'h00000, mask_id_high[m], mask_id_low[m][7:5]};
      end
      filt_match = ((fid ^ rx_id) & mid) == 29'h0
                   && (!mext || fext == rx_ext);
      if (f >= can_accept_pkg::BASE_FILTERS
          && op_mode == can_accept_pkg::MODE_LEGACY)
         filt_match = 1'b0;
      if (!filter_enable_bit[f])
         filt_match = 1'b0;
   endfunction

   logic       hit_any, next_accept;
   logic [3:0] hit_idx;
   always_comb begin
      hit_any = 1'b0;
      hit_idx = 4'h0;
      for (int f = can_accept_pkg::NUM_FILTERS - 1; f >= 0; f--) begin
         if (filt_match(f)) begin
            hit_any = 1'b1;
            hit_idx = 4'(f);
         end
      end
      next_accept = rx_valid ? hit_any : 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_accept     <= 1'b0;
         rx_filter_hit <= 4'h0;
         rx_done       <= 1'b0;
         last_accept   <= 1'b0;
         last_hit      <= 4'h0;
      end else begin
         rx_accept     <= next_accept;
         rx_filter_hit <= rx_valid ? hit_idx : rx_filter_hit;
         rx_done       <= rx_valid;
         last_accept   <= rx_valid ? hit_any : last_accept;
         last_hit      <= rx_valid ? hit_idx : last_hit;
      end
   end

   // read channel: one cycle answer
   logic [31:0] rd_val, next_rdata;
   logic [1:0]  next_rresp;
   logic        next_rvalid;
   logic [3:0]  rf;
   logic        rm;
   always_comb begin
      rf     = s_axi_araddr[5:2];
      rm     = s_axi_araddr[2];
      rd_val = 32'h0000_0000;
      if (s_axi_araddr == can_accept_pkg::ADDR_BSEL)
         rd_val = {24'h000000, buffer_direction_select};
      else if (s_axi_araddr == can_accept_pkg::ADDR_MODE)
         rd_val = {30'h0, op_mode};
      else if (s_axi_araddr == can_accept_pkg::ADDR_FEN)
         rd_val = {filter_mask_sel, filter_enable_bit};
      else if (s_axi_araddr == can_accept_pkg::ADDR_RESULT)
         rd_val = {27'h0, last_accept, last_hit};
      else if (s_axi_araddr[11:6] == can_accept_pkg::ADDR_FILT[11:6])
         rd_val = {filter_id_high[rf],
                   filter_id_low[rf] & (can_accept_pkg::SIDL_IMPL | 8'h08),
                   filter_ext_id_high[rf], filter_ext_id_low[rf]};
      else if (s_axi_araddr[11:3] == can_accept_pkg::ADDR_MASK[11:3])
         rd_val = {mask_id_high[rm],
                   mask_id_low[rm] & can_accept_pkg::SIDL_IMPL
                   | {4'h0, mask_ext_sel[rm]
                      && op_mode != can_accept_pkg::MODE_LEGACY, 3'h0},
                   mask_ext_id_high[rm], mask_ext_id_low[rm]};
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rdata  = s_axi_rdata;
      next_rresp  = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rdata  = addr_ok(s_axi_araddr) ? rd_val : 32'h0000_0000;
         next_rresp  = addr_ok(s_axi_araddr) ? can_accept_pkg::RESP_OKAY
                                             : can_accept_pkg::RESP_SLVERR;
      end
   end
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end else begin
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rresp;
      end
   end

   // checks
   a_bsel_low_zero: assert property (
      @(posedge aclk) disable iff (!aresetn)
      buffer_direction_select[1:0] == 2'h0)
      else $error("direction low bits not zero");
   a_mask_ext_legacy: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && op_mode == can_accept_pkg::MODE_LEGACY
       && $past(s_axi_araddr[11:3]) == can_accept_pkg::ADDR_MASK[11:3]
       && $past(s_axi_arvalid && s_axi_arready))
      |-> s_axi_rdata[16 + can_accept_pkg::EXT_BIT] == 1'b0)
      else $error("mask frame bit visible in mode 0");
   // the enable word is shifted so the index is the current hit, not a past one
   a_disabled_no_hit: assert property (
      @(posedge aclk) disable iff (!aresetn)
      rx_accept |-> (($past(filter_enable_bit) >> rx_filter_hit) & 16'h0001)
                    != 16'h0000)
      else $error("disabled filter accepted");
   a_legacy_high: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (rx_accept && $past(op_mode) == can_accept_pkg::MODE_LEGACY)
      |-> rx_filter_hit < 4'(can_accept_pkg::BASE_FILTERS))
      else $error("high filter hit in mode 0");
   a_accept_follows: assert property (
      @(posedge aclk) disable iff (!aresetn)
      rx_accept |-> $past(rx_valid))
      else $error("accept without valid id");
   a_dir_output: assert property (
      @(posedge aclk) disable iff (!aresetn)
      buffer_tx_direction_bits == buffer_direction_select[7:2])
      else $error("direction bits mismatch");
   a_filt_low_zero: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (wr_filt && w_strb[2]) |=> (filter_id_low[$past(wr_fidx)] & 8'h14) == 8'h0)
      else $error("filter low reserved bits set");
   a_mask_low_zero: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (wr_mask && w_strb[2]) |=> (mask_id_low[$past(wr_midx)] & 8'h1c) == 8'h0)
      else $error("mask low reserved bits set");
endmodule // can_accept_filter
`default_nettype wire

// ===== tb/can_rx_source.sv
// protocol engine stand-in that hands received identifiers to the filter
`timescale 1ns/1ps
`default_nettype none
module can_rx_source (
   // clock
   input  wire logic        aclk,
   // identifier towards the filter
   output logic [28:0]      rx_id,
   output logic             rx_ext,
   output logic             rx_valid
);
   logic sending;

   initial begin
      rx_id    = 29'h0;
      rx_ext   = 1'b0;
      rx_valid = 1'b0;
      sending  = 1'b0;
   end

   // between frames the id lines churn so a stale value can never pass
   always @(posedge aclk) begin
      if (!sending) begin
         rx_id  <= ~rx_id;
         rx_ext <= ~rx_ext;
      end
   end

   // one frame: identifier valid for exactly one cycle
   task automatic send(input logic [28:0] id, input logic ext);
      sending = 1'b1;
      @(posedge aclk);
      rx_id    <= id;
      rx_ext   <= ext;
      rx_valid <= 1'b1;
      @(posedge aclk);
      rx_valid <= 1'b0;
      sending = 1'b0;
   endtask
endmodule // can_rx_source
`default_nettype wire

// ===== tb/can_accept_filter_tb.sv
// self-checking bench for the acceptance filter register block
`timescale 1ns/1ps
`default_nettype none
module can_accept_filter_tb;
   logic        aclk, aresetn;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [28:0] rx_id;
   logic        rx_ext, rx_valid, rx_accept, rx_done;
   logic [3:0]  rx_filter_hit;
   logic [5:0]  buffer_tx_direction_bits;
   logic [31:0] rd;
   logic [1:0]  rr;
   int          fail_count, total_checks;

   can_accept_filter uut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .rx_id(rx_id), .rx_ext(rx_ext),
      .rx_valid(rx_valid), .rx_accept(rx_accept),
      .rx_filter_hit(rx_filter_hit), .rx_done(rx_done),
      .buffer_tx_direction_bits(buffer_tx_direction_bits));

   can_rx_source src (.aclk(aclk), .rx_id(rx_id), .rx_ext(rx_ext),
                      .rx_valid(rx_valid));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic hang();
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
      give_verdict();
   endtask

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (n == 64) hang();
      check(32'(s_axi_bresp), 32'(er));
   endtask

   task automatic rdr(input logic [11:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (n == 64) hang();
      rd = s_axi_rdata;
      rr = s_axi_rresp;
   endtask

   task automatic frame(input logic [28:0] id, input logic ext,
                        input logic acc, input logic [3:0] hit);
      src.send(id, ext);
      #1;
      check(32'(rx_done), 32'h1);
      check(32'(rx_accept), 32'(acc));
      if (acc) check(32'(rx_filter_hit), 32'(hit));
   endtask

   // legacy mode straight after reset
   task automatic t_reset();
      rdr(can_accept_pkg::ADDR_MODE);
      check(rd, 32'h0);
      rdr(can_accept_pkg::ADDR_BSEL);
      check(32'(rr), 32'(can_accept_pkg::RESP_SLVERR));
      check(32'(buffer_tx_direction_bits), 32'h0);
      rdr(can_accept_pkg::ADDR_MASK);
      check(rd & 32'h001c0000, 32'h0);
      rdr(12'h300);
      check({rd[29:0], rr}, {30'h0, can_accept_pkg::RESP_SLVERR});
      rdr(can_accept_pkg::ADDR_ID);
      check(rd, 32'h0);
      wr(can_accept_pkg::ADDR_FILT + 12'h018, 32'h0,
         can_accept_pkg::RESP_SLVERR);
      wr(can_accept_pkg::ADDR_MASK, 32'hffffffff, can_accept_pkg::RESP_OKAY);
      rdr(can_accept_pkg::ADDR_MASK);
      check(rd, 32'hffe3ffff);
      wr(can_accept_pkg::ADDR_FILT, 32'hffffffff, can_accept_pkg::RESP_OKAY);
      rdr(can_accept_pkg::ADDR_FILT);
      check(rd, 32'hffebffff);
      $display("test reset_and_legacy done");
   endtask

   task automatic t_regs();
      wr(can_accept_pkg::ADDR_MODE, 32'h1, can_accept_pkg::RESP_OKAY);
      rdr(can_accept_pkg::ADDR_FEN);
      check(rd, 32'h0000003f);
      wr(can_accept_pkg::ADDR_BSEL, 32'hff, can_accept_pkg::RESP_OKAY);
      rdr(can_accept_pkg::ADDR_BSEL);
      check(rd, 32'hfc);
      check(32'(buffer_tx_direction_bits), 32'h3f);
      wr(can_accept_pkg::ADDR_BSEL, 32'h24, can_accept_pkg::RESP_OKAY);
      check(32'(buffer_tx_direction_bits), 32'h09);
      wr(can_accept_pkg::ADDR_MASK + 12'h4, 32'hffffffff,
         can_accept_pkg::RESP_OKAY);
      rdr(can_accept_pkg::ADDR_MASK + 12'h4);
      check(rd, 32'hffebffff);
      wr(can_accept_pkg::ADDR_FILT + 12'h03c, 32'hffffffff,
         can_accept_pkg::RESP_OKAY);
      rdr(can_accept_pkg::ADDR_FILT + 12'h03c);
      check(rd, 32'hffebffff);
      $display("test register_access done");
   endtask

   // filter 0 holds standard id 0x123; mask 0 compares every sid bit
   task automatic t_match();
      wr(can_accept_pkg::ADDR_FEN, 32'h1, can_accept_pkg::RESP_OKAY);
      wr(can_accept_pkg::ADDR_FILT, 32'h24600000, can_accept_pkg::RESP_OKAY);
      wr(can_accept_pkg::ADDR_MASK, 32'hffe80000, can_accept_pkg::RESP_OKAY);
      frame(29'h123, 1'b0, 1'b1, 4'h0);
      frame(29'h122, 1'b0, 1'b0, 4'h0);
      frame(29'h048c0000, 1'b1, 1'b0, 4'h0);
      wr(can_accept_pkg::ADDR_MASK, 32'hffe00000, can_accept_pkg::RESP_OKAY);
      frame(29'h048fffff, 1'b1, 1'b1, 4'h0);
      frame(29'h123, 1'b0, 1'b1, 4'h0);
      wr(can_accept_pkg::ADDR_FEN, 32'h0, can_accept_pkg::RESP_OKAY);
      frame(29'h123, 1'b0, 1'b0, 4'h0);
      // filter 15 on mask 1, first standard then extended-only
      wr(can_accept_pkg::ADDR_FEN, 32'h80008000, can_accept_pkg::RESP_OKAY);
      wr(can_accept_pkg::ADDR_MASK + 12'h4, 32'hffe80000,
         can_accept_pkg::RESP_OKAY);
      wr(can_accept_pkg::ADDR_FILT + 12'h03c, 32'h24600000,
         can_accept_pkg::RESP_OKAY);
      frame(29'h123, 1'b0, 1'b1, 4'hf);
      wr(can_accept_pkg::ADDR_FILT + 12'h03c, 32'h24680000,
         can_accept_pkg::RESP_OKAY);
      frame(29'h123, 1'b0, 1'b0, 4'h0);
      frame(29'h048c0000, 1'b1, 1'b1, 4'hf);
      rdr(can_accept_pkg::ADDR_RESULT);
      check(rd, 32'h0000001f);
      $display("test acceptance done");
   endtask

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   initial begin
      fail_count = 0;
      total_checks = 0;
      aresetn = 1'b0;
      s_axi_awaddr = 12'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b1;
      s_axi_araddr = 12'h0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_regs();
      t_match();
      give_verdict();
   end
endmodule // can_accept_filter_tb
`default_nettype wire
